// ---- bench/cmag_gate_properties.sv ----
// Concurrent checks on the ports of the access gate.
`timescale 1ns/10ps

module cmag_gate_properties (
    // Clock and reset.
    input wire logic                aclk,
    input wire logic                aresetn,
    // Bus handshakes.
    input wire logic                awvalid,
    input wire logic                awready,
    input wire logic                wvalid,
    input wire logic                wready,
    input wire logic                bvalid,
    input wire logic                bready,
    input wire logic [1:0]          bresp,
    input wire logic                arvalid,
    input wire logic                arready,
    input wire logic                rvalid,
    input wire logic                rready,
    input wire logic [31:0]         rdata,
    // Grant strobes.
    input wire logic                cfg_rd_go,
    input wire logic                cfg_wr_go,
    input wire cmag_pkg::cmag_req_s cfg_req,
    input wire logic                config_locked
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_b_lat;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_lat;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_go_once;
        cfg_wr_go || cfg_rd_go |=> !cfg_wr_go && !cfg_rd_go;
    endproperty
    a_go_once: assert property (p_go_once) else $error("grant pulse too long");
    property p_go_b;
        cfg_wr_go || cfg_rd_go |-> $rose(bvalid) && cfg_req.is_write == cfg_wr_go;
    endproperty
    a_go_b: assert property (p_go_b) else $error("grant pulse misplaced");
    property p_never;
        cfg_wr_go || cfg_rd_go |-> cfg_req.area < cmag_pkg::AREA_RESERVED;
    endproperty
    a_never: assert property (p_never) else $error("reserved area granted");
    property p_ro;
        cfg_wr_go |-> !(cfg_req.area inside {cmag_pkg::AREA_SERIAL, cmag_pkg::AREA_HWREV});
    endproperty
    a_ro: assert property (p_ro) else $error("read-only area written");
    property p_locked;
        cfg_wr_go && config_locked |->
            cfg_req.area inside {cmag_pkg::AREA_MTZ, cmag_pkg::AREA_PASSWORD, cmag_pkg::AREA_PAC};
    endproperty
    a_locked: assert property (p_locked) else $error("locked area written");
    property p_lock_keep;
        config_locked |=> config_locked;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock released");

    // Main scenarios reached.
    c_wr_go: cover property (cfg_wr_go);
    c_rd_go: cover property (cfg_rd_go);
    c_slverr: cover property (bvalid && bresp == 2'h2);
endmodule // cmag_gate_properties

// ---- bench/cmag_rdr.sv ----
// Reader model driving register commands.
`timescale 1ns/10ps

module cmag_rdr (
    // Clock.
    input  wire logic        aclk,
    // Write channels.
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels.
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // Idle bus at time zero.
    initial begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // One write; taken payloads are inverted so stale values show.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awaddr <= ~a;
            if (awready) awvalid <= 1'b0;
            if (wvalid && wready) wdata <= ~d;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b1;
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    // One read; rready follows rvalid by a cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule // cmag_rdr

// ---- bench/tb_top.sv ----
// Testbench for the access gate: sweeps every area in every fuse column.
`timescale 1ns/10ps

module tb_top;
    logic                aclk;
    logic                aresetn;
    logic [7:0]          awaddr, araddr;
    logic [2:0]          awprot = 3'h0, arprot = 3'h0;
    logic [31:0]         wdata, rdata, d;
    logic [3:0]          wstrb = 4'hf;
    logic [1:0]          bresp, rresp, r;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic                cfg_rd_go, cfg_wr_go, config_locked;
    cmag_pkg::cmag_req_s cfg_req;
    int                  err_count = 0;
    int                  n_tests = 0;
    int                  go_cnt = 0;
    int                  refs = 0;
    int                  cyc = 0;
    logic                tp, en;
    logic [7:0]          wpw;

    cmag_gate_top cmag_gate_top_i (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cfg_rd_go, .cfg_wr_go,
        .cfg_req, .config_locked);
    cmag_rdr cmag_rdr_i (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    // Free-running clock of 100 ns.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Counts grant pulses and cuts a hung run short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cfg_rd_go || cfg_wr_go) go_cnt <= go_cnt + 1;
        if (cyc == 30000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        n_tests++;
        if (got !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, got);
            err_count++;
        end
    endtask

    // Expected condition: 0 open, 1 forbidden, 2 transport, 3 plus encryption, 4 set password.
    function automatic logic [2:0] cond_of(int col, int a, logic w);
        case (a)
            0, 4: cond_of = !w ? 3'h0 : (col == 3 ? 3'h1 : 3'h2);
            1: cond_of = 3'h0;
            2, 3: cond_of = w ? 3'h1 : 3'h0;
            5, 6: cond_of = !w ? 3'h0 : (col >= 2 ? 3'h1 : 3'h2);
            7, 8: cond_of = col >= 2 ? 3'h1 : ((w && col == 1) ? 3'h3 : 3'h2);
            9: cond_of = col == 3 ? 3'h4 : ((w && col == 1) ? 3'h3 : 3'h2);
            10: cond_of = !w ? 3'h0 : (col == 3 ? 3'h4 : 3'h2);
            default: cond_of = 3'h1;
        endcase
    endfunction

    task automatic do_req(int col, int a, logic w, logic [2:0] s);
        logic [31:0] d;
        logic [1:0]  r;
        logic [2:0]  c;
        logic        g;
        int          n;
        c = cond_of(col, a, w);
        g = c == 3'h0 || (c == 3'h2 && tp) || (c == 3'h3 && tp && en) || (c == 3'h4 && wpw[s]);
        n = go_cnt;
        cmag_rdr_i.wr(8'h14, {21'h0, s, 3'h0, w, a[3:0]}, r);
        cmag_rdr_i.rd(8'h18, d, r);
        chk("result", {25'h0, c, 2'h0, !g, g}, d);
        chk("grant pulses", g, go_cnt - n);
        if (g) chk("granted request", {a[3:0], w, s}, cfg_req);
        refs += !g;
    endtask

    // Credentials: 0 none, 1 transport, 2 plus encryption, 3 set 2 write password only.
    task automatic t_column(int col);
        for (int st = 0; st < 4; st++) begin
            if (st == 0 || st == 3) cmag_rdr_i.wr(8'h10, 32'h1, r);
            if (st == 1) cmag_rdr_i.wr(8'h08, 32'h3, r);
            if (st == 2) cmag_rdr_i.wr(8'h0c, 32'h1, r);
            if (st == 3) cmag_rdr_i.wr(8'h08, 32'h21, r);
            tp = st == 1 || st == 2;
            en = st == 2;
            wpw = st == 3 ? 8'h04 : 8'h00;
            cmag_rdr_i.rd(8'h08, d, r);
            chk("credentials", {15'h0, en, wpw, 7'h0, tp}, d);
            for (int a = 0; a < 16; a++)
                for (int w = 0; w < 2; w++)
                    for (int s = 2; s < 8; s += 3)
                        do_req(col, a, w[0], s[2:0]);
        end
        $display("column %0d done", col);
    endtask

    // Out-of-order programming is refused, then the next fuse programs.
    task automatic t_fuse(int k);
        cmag_rdr_i.wr(8'h04, (k + 1) % 3, r);
        chk("fuse order", 2'h2, r);
        cmag_rdr_i.rd(8'h00, d, r);
        chk("fuses kept", 32'h7 >> k, d);
        cmag_rdr_i.wr(8'h04, k, r);
        chk("fuse program", 2'h0, r);
        cmag_rdr_i.rd(8'h00, d, r);
        chk("fuses", (32'h7 >> (k + 1)) | (k == 2 ? 32'h10 : 32'h0), d);
        chk("locked", k == 2, config_locked);
        $display("fuse step %0d done", k);
    endtask

    // Reset fuses and unmapped addresses.
    task automatic t_misc();
        cmag_rdr_i.rd(8'h00, d, r);
        chk("reset fuses", 32'h7, d);
        cmag_rdr_i.wr(8'h24, 32'h1, r);
        chk("unmapped write", 2'h2, r);
        cmag_rdr_i.rd(8'h20, d, r);
        chk("unmapped read", 2'h2, r);
        $display("reset and map done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_misc();
        for (int k = 0; k < 3; k++) begin
            t_column(k);
            t_fuse(k);
        end
        t_column(3);
        cmag_rdr_i.rd(8'h1c, d, r);
        chk("refusal count", refs, d);
        wrap_up();
    end
endmodule // tb_top

bind cmag_gate_top cmag_gate_properties cmag_gate_properties_i (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
    .rready, .rdata, .cfg_rd_go, .cfg_wr_go, .cfg_req, .config_locked);

// ---- include/cmag_consts.svh ----
// Offsets, field positions, reset values and bus codes of the config memory access gate.
`ifndef CMAG_CONSTS_SVH
`define CMAG_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define CMAG_OFS_FUSE     8'h00
`define CMAG_OFS_FPROG    8'h04
`define CMAG_OFS_CHECK    8'h08
`define CMAG_OFS_ENC      8'h0c
`define CMAG_OFS_SESSION  8'h10
`define CMAG_OFS_REQ      8'h14
`define CMAG_OFS_RESULT   8'h18
`define CMAG_OFS_REFCNT   8'h1c

// Field positions inside the command and status registers.
`define CMAG_CHECK_PASS_BIT   0
`define CMAG_CHECK_KIND_BIT   1
`define CMAG_CHECK_SET_LSB    4
`define CMAG_ENC_ON_BIT       0
`define CMAG_SESSION_CLR_BIT  0
`define CMAG_REQ_WRITE_BIT    4
`define CMAG_REQ_SET_LSB      8
`define CMAG_STAT_WPW_LSB     8
`define CMAG_STAT_ENC_BIT     16
`define CMAG_FUSE_LOCK_BIT    4

// Fuse bits after manufacture: factory fuse 0, encryption, secret-key, personalization 1.
`define CMAG_FUSE_RST     4'h7

// Fuse selectors written to the programming register.
`define CMAG_FSEL_ENC     2'h0
`define CMAG_FSEL_SKY     2'h1
`define CMAG_FSEL_PER     2'h2

// AXI response codes.
`define CMAG_RESP_OKAY    2'h0
`define CMAG_RESP_SLVERR  2'h2

// Saturation value of the refusal counter.
`define CMAG_REFCNT_MAX   16'hffff

`endif

// ---- include/cmag_pkg.sv ----
// Types shared by the config memory access gate modules.
package cmag_pkg;

    // Configuration memory register areas.
    typedef enum logic [3:0] {
        AREA_ANTICOL  = 4'h0,
        AREA_MTZ      = 4'h1,
        AREA_HWREV    = 4'h2,
        AREA_SERIAL   = 4'h3,
        AREA_ACCESS   = 4'h4,
        AREA_NC_DCR   = 4'h5,
        AREA_CRYPTO   = 4'h6,
        AREA_ENC_KEYS = 4'h7,
        AREA_SECRET   = 4'h8,
        AREA_PASSWORD = 4'h9,
        AREA_PAC      = 4'ha,
        AREA_RESERVED = 4'hb
    } cmag_area_e;

    // Access condition of one area and operation in one fuse column.
    typedef enum logic [2:0] {
        COND_OPEN   = 3'h0,
        COND_FORBID = 3'h1,
        COND_TP     = 3'h2,
        COND_TP_ENC = 3'h3,
        COND_WPW    = 3'h4
    } cmag_cond_e;

    // Security fuses, one bit each, 0 when programmed.
    typedef struct packed {
        logic factory_lock_fuse;
        logic encryption_enforce_fuse;
        logic secret_key_lock_fuse;
        logic personalization_lock_fuse;
    } cmag_fuse_s;

    // One configuration memory access request.
    typedef struct packed {
        cmag_area_e area;
        logic       is_write;
        logic [2:0] set;
    } cmag_req_s;

    // Whole state of the top module.
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        tp_ok;
        logic [7:0]  wpw_ok;
        logic        enc_on;
        cmag_req_s   last_req;
        logic        granted;
        logic        refused;
        cmag_cond_e  last_cond;
        logic [15:0] refcnt;
        logic        rd_go;
        logic        wr_go;
        cmag_req_s   cfg_req;
        logic        locked;
    } cmag_top_s;

endpackage

// ---- verilog/cmag_access_rule.sv ----
// Access condition lookup and grant decision for one request.
`timescale 1ns/10ps

module cmag_access_rule (
    // Request and fuse state.
    input  cmag_pkg::cmag_req_s     req,
    input  cmag_pkg::cmag_fuse_s    fuse,
    // Session credentials.
    input  wire logic               tp_ok,
    input  wire logic               enc_on,
    input  wire logic [7:0]         wpw_ok,
    // Decision.
    output cmag_pkg::cmag_cond_e    cond,
    output logic                    grant
);

    logic [1:0] col;

    // Pick the fuse column; later fuses can only be set after earlier ones.
    always_comb begin
        if (!fuse.personalization_lock_fuse) begin
            col = 2'h3;
        end else if (!fuse.secret_key_lock_fuse) begin
            col = 2'h2;
        end else if (!fuse.encryption_enforce_fuse) begin
            col = 2'h1;
        end else begin
            col = 2'h0;
        end
    end

    // Condition table by area, operation and column.
    always_comb begin
        cond = cmag_pkg::COND_FORBID;
        case (req.area)
            cmag_pkg::AREA_MTZ: cond = cmag_pkg::COND_OPEN;
            cmag_pkg::AREA_HWREV, cmag_pkg::AREA_SERIAL:
                cond = req.is_write ? cmag_pkg::COND_FORBID : cmag_pkg::COND_OPEN;
            cmag_pkg::AREA_ANTICOL, cmag_pkg::AREA_ACCESS:
                cond = !req.is_write ? cmag_pkg::COND_OPEN :
                       (col == 2'h3) ? cmag_pkg::COND_FORBID : cmag_pkg::COND_TP;
            cmag_pkg::AREA_NC_DCR, cmag_pkg::AREA_CRYPTO:
                cond = !req.is_write ? cmag_pkg::COND_OPEN :
                       (col >= 2'h2) ? cmag_pkg::COND_FORBID : cmag_pkg::COND_TP;
            cmag_pkg::AREA_ENC_KEYS, cmag_pkg::AREA_SECRET: begin
                if (col >= 2'h2) begin
                    cond = cmag_pkg::COND_FORBID;
                end else if (req.is_write && col == 2'h1) begin
                    cond = cmag_pkg::COND_TP_ENC;
                end else begin
                    cond = cmag_pkg::COND_TP;
                end
            end
            cmag_pkg::AREA_PASSWORD: begin
                if (col == 2'h3) begin
                    cond = cmag_pkg::COND_WPW;
                end else if (req.is_write && col == 2'h1) begin
                    cond = cmag_pkg::COND_TP_ENC;
                end else begin
                    cond = cmag_pkg::COND_TP;
                end
            end
            cmag_pkg::AREA_PAC:
                cond = !req.is_write ? cmag_pkg::COND_OPEN :
                       (col == 2'h3) ? cmag_pkg::COND_WPW : cmag_pkg::COND_TP;
            default: cond = cmag_pkg::COND_FORBID;
        endcase
    end

    // Grant when the credentials of the condition are held.
    always_comb begin
        case (cond)
            cmag_pkg::COND_OPEN:   grant = 1'b1;
            cmag_pkg::COND_TP:     grant = tp_ok;
            cmag_pkg::COND_TP_ENC: grant = tp_ok && enc_on;
            cmag_pkg::COND_WPW:    grant = wpw_ok[req.set];
            default:               grant = 1'b0;
        endcase
    end

endmodule // cmag_access_rule

// ---- verilog/cmag_fuse_bank.sv ----
// Security fuse bank with fixed programming order.
`timescale 1ns/10ps
`include "cmag_consts.svh"

module cmag_fuse_bank (
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Programming request.
    input  wire logic               prog_valid,
    input  wire logic [1:0]         prog_sel,
    // Fuse state and order check.
    output cmag_pkg::cmag_fuse_s    fuse,
    output logic                    prog_legal
);

    cmag_pkg::cmag_fuse_s fuse_q;
    cmag_pkg::cmag_fuse_s fuse_d;

    // A fuse may only follow the one before it in the order.
    always_comb begin
        fuse_d = fuse_q;
        case (prog_sel)
            `CMAG_FSEL_ENC: prog_legal = fuse_q.encryption_enforce_fuse;
            `CMAG_FSEL_SKY: prog_legal = !fuse_q.encryption_enforce_fuse
                                         && fuse_q.secret_key_lock_fuse;
            `CMAG_FSEL_PER: prog_legal = !fuse_q.secret_key_lock_fuse
                                         && fuse_q.personalization_lock_fuse;
            default:        prog_legal = 1'b0;
        endcase
        if (prog_valid && prog_legal) begin
            case (prog_sel)
                `CMAG_FSEL_ENC: fuse_d.encryption_enforce_fuse = 1'b0;
                `CMAG_FSEL_SKY: fuse_d.secret_key_lock_fuse = 1'b0;
                default:        fuse_d.personalization_lock_fuse = 1'b0;
            endcase
        end
    end

    // Fuses start in the shipped state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_q <= cmag_pkg::cmag_fuse_s'(`CMAG_FUSE_RST);
        end else begin
            fuse_q <= fuse_d;
        end
    end

    assign fuse = fuse_q;

endmodule // cmag_fuse_bank

// ---- verilog/cmag_gate_top.sv ----
// Configuration memory access gate with AXI4-Lite command and status registers.
`timescale 1ns/10ps
`include "cmag_consts.svh"

module cmag_gate_top (
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [7:0]         awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               awvalid,
    output logic                    awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    // AXI4-Lite write response channel.
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // AXI4-Lite read address channel.
    input  wire logic [7:0]         araddr,
    input  wire logic [2:0]         arprot,
    input  wire logic               arvalid,
    output logic                    arready,
    // AXI4-Lite read data channel.
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Configuration memory strobes.
    output logic                    cfg_rd_go,
    output logic                    cfg_wr_go,
    output cmag_pkg::cmag_req_s     cfg_req,
    output logic                    config_locked
);

    cmag_pkg::cmag_top_s  s_q;
    cmag_pkg::cmag_top_s  s_d;
    cmag_pkg::cmag_fuse_s fuse;
    cmag_pkg::cmag_req_s  req_now;
    cmag_pkg::cmag_cond_e cond_now;
    logic                 grant_now;
    logic                 prog_valid;
    logic                 prog_legal;
    logic [7:0]           wr_word;
    logic [7:0]           rd_word;

    // Expand byte strobes into a bit mask.
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Word-align a byte address.
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    // Register read multiplexer; unmapped words answer with an error.
    function automatic logic [33:0] read_word(input logic [7:0] a,
                                              input cmag_pkg::cmag_top_s s,
                                              input cmag_pkg::cmag_fuse_s f);
        logic [31:0] d;
        logic [1:0]  r;
        d = '0;
        r = `CMAG_RESP_OKAY;
        if (a == `CMAG_OFS_FUSE) begin
            d[3:0] = f;
            d[`CMAG_FUSE_LOCK_BIT] = s.locked;
        end else if (a == `CMAG_OFS_FPROG) begin
            d = '0;
        end else if (a == `CMAG_OFS_CHECK) begin
            d[0] = s.tp_ok;
            d[`CMAG_STAT_WPW_LSB +: 8] = s.wpw_ok;
            d[`CMAG_STAT_ENC_BIT] = s.enc_on;
        end else if (a == `CMAG_OFS_ENC) begin
            d[`CMAG_ENC_ON_BIT] = s.enc_on;
        end else if (a == `CMAG_OFS_SESSION) begin
            d = '0;
        end else if (a == `CMAG_OFS_REQ) begin
            d[3:0] = s.last_req.area;
            d[`CMAG_REQ_WRITE_BIT] = s.last_req.is_write;
            d[`CMAG_REQ_SET_LSB +: 3] = s.last_req.set;
        end else if (a == `CMAG_OFS_RESULT) begin
            d[0] = s.granted;
            d[1] = s.refused;
            d[6:4] = s.last_cond;
        end else if (a == `CMAG_OFS_REFCNT) begin
            d[15:0] = s.refcnt;
        end else begin
            r = `CMAG_RESP_SLVERR;
        end
        return {r, d};
    endfunction

    assign wr_word = word_addr(s_q.awaddr);
    assign rd_word = word_addr(araddr);

    // Request fields taken from the pending write data.
    always_comb begin
        req_now.area = cmag_pkg::cmag_area_e'(s_q.wdata[3:0]);
        req_now.is_write = s_q.wdata[`CMAG_REQ_WRITE_BIT];
        req_now.set = s_q.wdata[`CMAG_REQ_SET_LSB +: 3];
    end

    // Fuses and their programming order.
    cmag_fuse_bank u_fuse (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .prog_valid (prog_valid),
        .prog_sel   (s_q.wdata[1:0]),
        .fuse       (fuse),
        .prog_legal (prog_legal)
    );

    // Access condition and decision for the pending request.
    cmag_access_rule u_rule (
        .req    (req_now),
        .fuse   (fuse),
        .tp_ok  (s_q.tp_ok),
        .enc_on (s_q.enc_on),
        .wpw_ok (s_q.wpw_ok),
        .cond   (cond_now),
        .grant  (grant_now)
    );

    // Next state: bus handshakes, command decode and the decision record.
    always_comb begin
        s_d = s_q;
        prog_valid = 1'b0;
        s_d.rd_go = 1'b0;
        s_d.wr_go = 1'b0;

        // Address and data are taken independently, in either order.
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata & strb_mask(wstrb);
        end

        // Response is released once the master takes it.
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // Both halves present: perform the write and answer.
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `CMAG_RESP_OKAY;
            if (wr_word == `CMAG_OFS_FPROG) begin
                prog_valid = 1'b1;
                if (!prog_legal) begin
                    s_d.bresp = `CMAG_RESP_SLVERR;
                end
            end else if (wr_word == `CMAG_OFS_CHECK) begin
                // A passing password check opens its credential for the session.
                if (s_q.wdata[`CMAG_CHECK_PASS_BIT]) begin
                    if (s_q.wdata[`CMAG_CHECK_KIND_BIT]) begin
                        s_d.tp_ok = 1'b1;
                    end else begin
                        s_d.wpw_ok[s_q.wdata[`CMAG_CHECK_SET_LSB +: 3]] = 1'b1;
                    end
                end
            end else if (wr_word == `CMAG_OFS_ENC) begin
                s_d.enc_on = s_q.wdata[`CMAG_ENC_ON_BIT];
            end else if (wr_word == `CMAG_OFS_SESSION) begin
                // Ending the session drops every credential.
                if (s_q.wdata[`CMAG_SESSION_CLR_BIT]) begin
                    s_d.tp_ok = 1'b0;
                    s_d.wpw_ok = '0;
                    s_d.enc_on = 1'b0;
                end
            end else if (wr_word == `CMAG_OFS_REQ) begin
                s_d.last_req = req_now;
                s_d.last_cond = cond_now;
                s_d.granted = grant_now;
                s_d.refused = !grant_now;
                if (grant_now) begin
                    // Only a granted access strobes the memory.
                    s_d.cfg_req = req_now;
                    s_d.rd_go = !req_now.is_write;
                    s_d.wr_go = req_now.is_write;
                end else if (s_q.refcnt != `CMAG_REFCNT_MAX) begin
                    s_d.refcnt = s_q.refcnt + 16'h0001;
                end
            end else if (wr_word == `CMAG_OFS_FUSE || wr_word == `CMAG_OFS_RESULT
                         || wr_word == `CMAG_OFS_REFCNT) begin
                // Status words ignore writes.
                s_d.bresp = `CMAG_RESP_OKAY;
            end else begin
                s_d.bresp = `CMAG_RESP_SLVERR;
            end
        end

        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;

        // Read channel: one read at a time, answered the cycle after the address.
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            {s_d.rresp, s_d.rdata} = read_word(rd_word, s_q, fuse);
        end
        s_d.arready = !s_d.rvalid;

        // All three user fuses programmed locks the configuration.
        s_d.locked = !fuse.encryption_enforce_fuse && !fuse.secret_key_lock_fuse
                     && !fuse.personalization_lock_fuse;
    end

    // State register; ready flags come up one cycle after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = s_q.rdata;
    assign cfg_rd_go = s_q.rd_go;
    assign cfg_wr_go = s_q.wr_go;
    assign cfg_req = s_q.cfg_req;
    assign config_locked = s_q.locked;

endmodule // cmag_gate_top
